// *** inc/hcw_pkg.sv ***
// Shared constants, types and helper functions of the rolling-code word transmitter.
// Assumes a single 200 MHz clock; clock and tick counts are derived here from their times, frame lengths are given in thirds.
package hcw_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam real CLK_PERIOD_NS         = 5.0;
	localparam real ENTRY_HOLD_TIME_MS    = 9.0;
	localparam real ENTRY_SETUP_TIME_MS   = 4.0;
	localparam real WRITE_TIME_MS         = 30.0;
	localparam real MS_TICK_TIME_MS       = 1.0;
	localparam real THIRD_CELL_TIME_US    = 133.0;
	localparam real TIMEOUT_TIME_S        = 25.0;
	localparam real LED_HALF_TIME_MS      = 500.0;
	localparam int  ENTRY_HOLD_CYC  = int'($ceil(ENTRY_HOLD_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int  ENTRY_SETUP_CYC = int'($floor(ENTRY_SETUP_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int  WRITE_CYC       = int'($floor(WRITE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int  MS_TICK_CYC     = int'($floor(MS_TICK_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int  THIRD_CELL_CYC  = int'($floor(THIRD_CELL_TIME_US * 1.0e3 / CLK_PERIOD_NS));
	localparam logic [14:0] TIMEOUT_MS_TICKS = 15'($rtoi(TIMEOUT_TIME_S * 1000.0 / MS_TICK_TIME_MS));
	localparam logic [9:0]  LED_HALF_TICKS   = 10'($rtoi(LED_HALF_TIME_MS / MS_TICK_TIME_MS));
	// Frame lengths in thirds of a bit cell.
	localparam logic [7:0] PREAMBLE_THIRDS = 8'h24;
	localparam logic [7:0] HEADER_THIRDS   = 8'h1E;
	localparam logic [7:0] GUARD_THIRDS    = 8'h75;

	// ----------------------------------------------------------------
	// Code word layout
	// ----------------------------------------------------------------
	localparam logic [6:0] CRC_LAST_IDX = 7'h40;
	localparam logic [6:0] CRC0_IDX     = 7'h41;
	localparam logic [6:0] WORD_LAST_IDX = 7'h42;
	localparam logic [1:0] WORDS_MIN    = 2'h2;
	localparam logic [3:0] PROG_LAST_WORD = 4'hB;
	localparam logic [7:0] PROG_LAST_BIT  = 8'hBF;
	localparam logic [5:0] PROG_PAIR_LAST = 6'h1F;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        long_guard_enable;
		logic        timeout_enable;
		logic        extended_serial_select;
		logic        independent_mode;
		logic        overflow_enable;
		logic [1:0]  user_bits;
		logic [31:0] serial_number;
	} hcw_config_t;

	typedef struct packed {
		logic data;
		logic oe_n;
	} hcw_pin_t;

	typedef enum logic [7:0] {
		TX_IDLE = 8'h01, TX_PREP = 8'h02, TX_LOAD = 8'h04, TX_PREAMBLE = 8'h08,
		TX_HEADER = 8'h10, TX_DATA = 8'h20, TX_GUARD = 8'h40, TX_TIMEOUT = 8'h80
	} hcw_tx_fsm_t;

	typedef enum logic [6:0] {
		PG_IDLE = 7'h01, PG_SETUP = 7'h02, PG_SHIFT = 7'h04, PG_WRITE = 7'h08,
		PG_ACK = 7'h10, PG_VERIFY = 7'h20, PG_EXIT = 7'h40
	} hcw_pg_fsm_t;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [1:0] crc_step(input logic [1:0] crc, input logic d);
		crc_step = {crc[0] ^ d, crc[0] ^ d ^ crc[1]};
	endfunction : crc_step

	function automatic logic [1:0] crc_over(input logic [64:0] bits);
		logic [1:0] c;
		c = 2'h0;
		for (int n = 0; n < 65; n++) begin
			c = crc_step(c, bits[n]);
		end
		crc_over = c;
	endfunction : crc_over

	function automatic logic tx_bit(input logic [66:0] word, input logic [6:0] idx, input logic [1:0] crc);
		if (idx <= CRC_LAST_IDX) tx_bit = word[idx];
		else if (idx == CRC0_IDX) tx_bit = crc[0];
		else tx_bit = crc[1];
	endfunction : tx_bit
endpackage : hcw_pkg

// *** core/hcw_divider.sv ***
// Free-running divider giving a one-cycle enable pulse every PERIOD_CYC clocks.
// Assumes a synchronous active-high reset.
`timescale 1ns/100ps
module hcw_divider #(
	parameter int PERIOD_CYC = 2
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_srst,
	// Enable pulse
	output logic      o_tick
);
	localparam int CW = $clog2(PERIOD_CYC + 1);
	typedef struct packed {
		logic [CW-1:0] count;
		logic          tick;
	} hcw_div_state_t;
	hcw_div_state_t cq, nx;

	always_comb begin
		nx = cq;
		nx.tick = 1'b0;
		if (cq.count == CW'(PERIOD_CYC - 1)) begin
			nx.count = '0;
			nx.tick = 1'b1;
		end else begin
			nx.count = cq.count + CW'(1);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) cq <= '0;
		else cq <= nx;
	end

	assign o_tick = cq.tick;
endmodule : hcw_divider

// *** core/hcw_prog_port.sv ***
// Serial programming and one-shot verify port of the nonvolatile parameters.
// Assumes button and pin levels are synchronous; the clock line is button 3 or 2.
`timescale 1ns/100ps
module hcw_prog_port #(
	parameter int HOLD_CYC  = hcw_pkg::ENTRY_HOLD_CYC,
	parameter int SETUP_CYC = hcw_pkg::ENTRY_SETUP_CYC,
	parameter int WRITE_CYC = hcw_pkg::WRITE_CYC
) (
	// Clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_srst,
	// Pins
	input  wire logic [3:0]   i_button,
	input  wire logic         i_data,
	output hcw_pkg::hcw_pin_t o_pin,
	// Status and stored image
	output logic              o_busy,
	output logic [191:0]      o_mem,
	output logic              o_mem_valid
);
	typedef struct packed {
		hcw_pkg::hcw_pg_fsm_t st;
		logic [22:0]          cnt;
		logic                 hold_met;
		logic [31:0]          shreg;
		logic [5:0]           nbit;
		logic [3:0]           widx;
		logic [7:0]           vbit;
		logic [191:0]         mem;
		logic                 valid;
		logic                 clk;
		hcw_pkg::hcw_pin_t    pin;
	} hcw_pg_state_t;
	hcw_pg_state_t cq, nx;
	logic pclk;
	logic rise;
	logic fall;

	assign pclk = i_button[3] | i_button[2];
	assign rise = pclk & ~cq.clk;
	assign fall = ~pclk & cq.clk;

	always_comb begin
		nx = cq;
		nx.clk = pclk;
		nx.pin.oe_n = 1'b1;
		nx.pin.data = 1'b0;
		unique case (cq.st)
		hcw_pkg::PG_IDLE: begin
			if (i_button[3] && i_button[1:0] == 2'h0) begin
				if (cq.cnt == 23'(HOLD_CYC - 1)) nx.hold_met = 1'b1;
				else nx.cnt = cq.cnt + 23'h1;
			end else begin
				nx.cnt = 23'h0;
				if (cq.hold_met && !i_button[3]) nx.st = hcw_pkg::PG_SETUP;
				nx.hold_met = 1'b0;
			end
		end
		hcw_pkg::PG_SETUP: begin
			nx.cnt = cq.cnt + 23'h1;
			if (i_data) {nx.st, nx.nbit, nx.widx} = {hcw_pkg::PG_SHIFT, 6'h0, 4'h0};
			else if (cq.cnt >= 23'(SETUP_CYC)) {nx.st, nx.cnt} = {hcw_pkg::PG_IDLE, 23'h0};
		end
		hcw_pkg::PG_SHIFT: if (fall) begin
			nx.shreg = {i_data, cq.shreg[31:1]};
			nx.nbit = cq.nbit + 6'h1;
			if (cq.nbit == hcw_pkg::PROG_PAIR_LAST) begin
				nx.cnt = 23'h0;
				nx.st = (nx.shreg[15:0] == ~nx.shreg[31:16]) ? hcw_pkg::PG_WRITE : hcw_pkg::PG_EXIT;
			end
		end
		hcw_pkg::PG_WRITE: begin
			// The first word also bulk-erases the whole image.
			if (cq.cnt == 23'h0 && cq.widx == 4'h0) nx.mem = '0;
			nx.cnt = cq.cnt + 23'h1;
			if (cq.cnt == 23'(WRITE_CYC - 1)) begin
				nx.mem[cq.widx*16 +: 16] = cq.shreg[15:0];
				nx.st = hcw_pkg::PG_ACK;
			end
		end
		hcw_pkg::PG_ACK: begin
			{nx.pin.oe_n, nx.pin.data} = 2'b01;
			if (rise) begin
				nx.nbit = 6'h0;
				nx.widx = cq.widx + 4'h1;
				nx.vbit = 8'h1;
				nx.valid = (cq.widx == hcw_pkg::PROG_LAST_WORD);
				nx.st = (cq.widx == hcw_pkg::PROG_LAST_WORD) ? hcw_pkg::PG_VERIFY : hcw_pkg::PG_SHIFT;
				if (cq.widx == hcw_pkg::PROG_LAST_WORD) {nx.pin.oe_n, nx.pin.data} = {1'b0, cq.mem[0]};
			end
		end
		hcw_pkg::PG_VERIFY: begin
			{nx.pin.oe_n, nx.pin.data} = {1'b0, cq.pin.data};
			// Bit 0 went out with the last acknowledge, so each rise presents the next bit.
			if (rise && cq.vbit <= hcw_pkg::PROG_LAST_BIT) begin
				nx.pin.data = cq.mem[cq.vbit];
				nx.vbit = cq.vbit + 8'h1;
			end
			// The last bit stands through its high phase and is released on the fall.
			if (fall && cq.vbit > hcw_pkg::PROG_LAST_BIT) nx.st = hcw_pkg::PG_EXIT;
		end
		hcw_pkg::PG_EXIT: if (i_button == 4'h0) {nx.st, nx.cnt} = {hcw_pkg::PG_IDLE, 23'h0};
		default: nx.st = hcw_pkg::PG_IDLE;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			cq <= '0;
			cq.st <= hcw_pkg::PG_IDLE;
			cq.pin.oe_n <= 1'b1;
		end else begin
			cq <= nx;
		end
	end

	assign o_pin = cq.pin;
	assign o_busy = cq.hold_met | (cq.st != hcw_pkg::PG_IDLE);
	assign o_mem = cq.mem;
	assign o_mem_valid = cq.valid;
endmodule : hcw_prog_port

// *** core/hcw_transmitter.sv ***
// Rolling-code word transmitter: word assembly, framing, completion, guard, time-out, indicator.
// Assumes synchronous inputs and an outside cipher that answers i_hop_cipher from o_hop_plain
// within one clock.
//
// Overview of operation
// - Each frame is preamble, header, encrypted part, then fixed part.
// - The payload is 67 bits: 32 encrypted and 35 fixed.
// - A guard period follows every completed word before the next frame starts.
// - Encrypted block: function, independent, overflow, user, 8 serial, 16-bit counter.
// - Fixed block: low-battery flag, two checksum bits, function bits, 28-bit serial.
// - Extended serial sends all 32 serial bits and drops function bits.
// - Words shift out least significant bit first.
// - A started word completes unless a different button, time-out or programming cuts it; at least two words per activation.
// - Any button wakes; sleep after two words once buttons are released.
// - Held buttons keep producing fresh words.
// - A different button aborts the word and restarts with new buttons.
// - Long guard sends only every second word, other slots silent.
// - Checksum covers the 65 bits sent before it.
// - Checksum starts at zero and updates per bit with two XOR equations.
// - Time-out enable stops sending after about 25 s of holding.
// - Every word carries the low-battery flag from the supply detector.
// - Indicator low while sending; toggles near 1 Hz on low supply.
// - Programming data is 16-bit words plus complement, 192 bits in all.
// - Each word is written within 30 ms then acknowledged; first also erases.
// - Verify works once, straight after programming; otherwise nothing is driven.
// - Time-out forces data low and indicator off until all buttons are low.
// - Without extended serial, function bits replace the top four serial bits.
`timescale 1ns/100ps
module hcw_transmitter #(
	parameter int MS_TICK_CYC    = hcw_pkg::MS_TICK_CYC,
	parameter int THIRD_CELL_CYC = hcw_pkg::THIRD_CELL_CYC,
	parameter int ENTRY_HOLD_CYC = hcw_pkg::ENTRY_HOLD_CYC,
	parameter int ENTRY_SETUP_CYC = hcw_pkg::ENTRY_SETUP_CYC,
	parameter int WRITE_CYC      = hcw_pkg::WRITE_CYC
) (
	// Clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_srst,
	// Buttons, supply detector and configuration
	input  wire logic [3:0]           i_button,
	input  wire logic                 i_low_supply_indicator,
	input  wire hcw_pkg::hcw_config_t i_config,
	// Cipher hand-off
	input  wire logic [31:0]          i_hop_cipher,
	output logic [31:0]               o_hop_plain,
	// Transmit data pin
	input  wire logic                 i_tx_pin,
	output logic                      o_tx_data,
	output logic                      o_tx_oe_n,
	// Indicator and status
	output logic                      o_indicator_output_n,
	output logic                      o_awake,
	// Programmed parameter image
	output logic [191:0]              o_nv_data,
	output logic                      o_nv_valid
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		hcw_pkg::hcw_tx_fsm_t st;
		logic [66:0]          word;
		logic [6:0]           bit_idx;
		logic [1:0]           phase;
		logic [7:0]           thirds;
		logic [1:0]           crc;
		logic [3:0]           func;
		logic [1:0]           words_done;
		logic                 silent;
		logic [15:0]          sync;
		logic                 ovr_cleared;
		logic [14:0]          hold_ms;
		logic [9:0]           led_ms;
		logic                 led_blink;
		logic                 tx;
		logic [31:0]          hop_plain;
		logic                 out_tx;
		logic                 out_oe_n;
		logic                 led_n;
		logic                 awake;
	} hcw_tx_state_t;
	hcw_tx_state_t cq, nx;

	logic              ms_tick;
	logic              third_tick;
	logic              prog_busy;
	hcw_pkg::hcw_pin_t prog_pin;
	logic              cur_bit;
	logic              framing;
	logic [1:0]        done_n;

	// ----------------------------------------------------------------
	// Dividers and programming port
	// ----------------------------------------------------------------
	hcw_divider #(.PERIOD_CYC(MS_TICK_CYC)) u_ms_div (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.o_tick  (ms_tick)
	);

	hcw_divider #(.PERIOD_CYC(THIRD_CELL_CYC)) u_cell_div (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.o_tick  (third_tick)
	);

	hcw_prog_port #(
		.HOLD_CYC  (ENTRY_HOLD_CYC),
		.SETUP_CYC (ENTRY_SETUP_CYC),
		.WRITE_CYC (WRITE_CYC)
	) u_prog (
		.i_clock     (i_clock),
		.i_srst      (i_srst),
		.i_button    (i_button),
		.i_data      (i_tx_pin),
		.o_pin       (prog_pin),
		.o_busy      (prog_busy),
		.o_mem       (o_nv_data),
		.o_mem_valid (o_nv_valid)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	assign cur_bit = hcw_pkg::tx_bit(cq.word, cq.bit_idx, cq.crc);
	assign framing = cq.st inside {hcw_pkg::TX_PREAMBLE, hcw_pkg::TX_HEADER, hcw_pkg::TX_DATA};
	assign done_n = (cq.silent || cq.words_done == hcw_pkg::WORDS_MIN) ? cq.words_done : cq.words_done + 2'h1;

	always_comb begin
		nx = cq;
		// Hold time and indicator blink run on the millisecond enable.
		if (ms_tick) begin
			if (i_button == 4'h0) nx.hold_ms = 15'h0;
			else if (cq.hold_ms != hcw_pkg::TIMEOUT_MS_TICKS) nx.hold_ms = cq.hold_ms + 15'h1;
			if (cq.led_ms == hcw_pkg::LED_HALF_TICKS - 10'h1) begin
				nx.led_ms = 10'h0;
				nx.led_blink = ~cq.led_blink;
			end else begin
				nx.led_ms = cq.led_ms + 10'h1;
			end
		end
		unique case (cq.st)
		hcw_pkg::TX_IDLE: begin
			nx.words_done = 2'h0;
			nx.silent = 1'b0;
			nx.tx = 1'b0;
			if (i_button != 4'h0) nx.st = hcw_pkg::TX_PREP;
		end
		hcw_pkg::TX_PREP: begin
			if (i_button != 4'h0) nx.func = i_button;
			nx.sync = cq.sync + 16'h1;
			if (cq.sync == 16'hFFFF) nx.ovr_cleared = 1'b1;
			nx.hop_plain = {nx.func, i_config.independent_mode, i_config.overflow_enable & ~nx.ovr_cleared,
				i_config.user_bits, i_config.serial_number[7:0], nx.sync};
			nx.st = hcw_pkg::TX_LOAD;
		end
		hcw_pkg::TX_LOAD: begin
			nx.word[31:0] = i_hop_cipher;
			if (i_config.extended_serial_select) nx.word[63:32] = i_config.serial_number;
			else nx.word[63:32] = {cq.func, i_config.serial_number[27:0]};
			nx.word[64] = i_low_supply_indicator;
			nx.word[66:65] = 2'h0;
			nx.bit_idx = 7'h0;
			nx.phase = 2'h0;
			nx.thirds = 8'h0;
			nx.crc = 2'h0;
			nx.tx = 1'b0;
			nx.st = hcw_pkg::TX_PREAMBLE;
		end
		hcw_pkg::TX_PREAMBLE: if (third_tick) begin
			nx.tx = ~cq.tx;
			nx.thirds = cq.thirds + 8'h1;
			if (cq.thirds == hcw_pkg::PREAMBLE_THIRDS - 8'h1) begin
				nx.thirds = 8'h0;
				nx.tx = 1'b0;
				nx.st = hcw_pkg::TX_HEADER;
			end
		end
		hcw_pkg::TX_HEADER: if (third_tick) begin
			nx.thirds = cq.thirds + 8'h1;
			if (cq.thirds == hcw_pkg::HEADER_THIRDS - 8'h1) begin
				nx.thirds = 8'h0;
				nx.tx = 1'b1;
				nx.st = hcw_pkg::TX_DATA;
			end
		end
		hcw_pkg::TX_DATA: if (third_tick) begin
			unique case (cq.phase)
			2'h0: begin
				nx.phase = 2'h1;
				nx.tx = ~cur_bit;
			end
			2'h1: begin
				nx.phase = 2'h2;
				nx.tx = 1'b0;
			end
			default: begin
				nx.phase = 2'h0;
				// Checksum over bits 0 to 64
				if (cq.bit_idx <= hcw_pkg::CRC_LAST_IDX) nx.crc = hcw_pkg::crc_step(cq.crc, cur_bit);
				if (cq.bit_idx == hcw_pkg::WORD_LAST_IDX) begin
					nx.thirds = 8'h0;
					nx.tx = 1'b0;
					nx.st = hcw_pkg::TX_GUARD;
				end else begin
					nx.bit_idx = cq.bit_idx + 7'h1;
					nx.tx = 1'b1;
				end
			end
			endcase
		end
		hcw_pkg::TX_GUARD: begin
			nx.tx = 1'b0;
			if (third_tick) begin
				nx.thirds = cq.thirds + 8'h1;
				if (cq.thirds == hcw_pkg::GUARD_THIRDS - 8'h1) begin
					nx.words_done = done_n;
					nx.silent = i_config.long_guard_enable & ~cq.silent;
					if (i_button == 4'h0 && done_n == hcw_pkg::WORDS_MIN) nx.st = hcw_pkg::TX_IDLE;
					else nx.st = hcw_pkg::TX_PREP;
				end
			end
		end
		hcw_pkg::TX_TIMEOUT: begin
			nx.tx = 1'b0;
			// Leave only once all buttons are low
			if (i_button == 4'h0) nx.st = hcw_pkg::TX_IDLE;
		end
		default: nx.st = hcw_pkg::TX_IDLE;
		endcase
		if (framing && i_button != 4'h0 && i_button != cq.func) begin
			nx.st = hcw_pkg::TX_PREP;
			nx.tx = 1'b0;
		end
		if (i_config.timeout_enable && cq.hold_ms == hcw_pkg::TIMEOUT_MS_TICKS
			&& !(cq.st inside {hcw_pkg::TX_IDLE, hcw_pkg::TX_TIMEOUT})) begin
			nx.st = hcw_pkg::TX_TIMEOUT;
			nx.tx = 1'b0;
		end
		// Programming owns the pin; transmission is dropped, not resumed.
		if (prog_busy) begin
			nx.st = hcw_pkg::TX_IDLE;
			nx.tx = 1'b0;
		end
		nx.out_tx = prog_busy ? prog_pin.data : (nx.tx & ~nx.silent);
		nx.out_oe_n = prog_busy ? prog_pin.oe_n : 1'b0;
		nx.awake = nx.st != hcw_pkg::TX_IDLE;
		if (nx.st inside {hcw_pkg::TX_IDLE, hcw_pkg::TX_TIMEOUT}) nx.led_n = 1'b1;
		else nx.led_n = i_low_supply_indicator ? nx.led_blink : 1'b0;
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			cq <= '0;
			cq.st <= hcw_pkg::TX_IDLE;
			cq.led_n <= 1'b1;
		end else begin
			cq <= nx;
		end
	end

	assign o_tx_data = cq.out_tx;
	assign o_tx_oe_n = cq.out_oe_n;
	assign o_indicator_output_n = cq.led_n;
	assign o_awake = cq.awake;
	assign o_hop_plain = cq.hop_plain;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	header_order_a: assert property (
		$rose(cq.st == hcw_pkg::TX_HEADER) |-> $past(cq.st) == hcw_pkg::TX_PREAMBLE)
		else $error("Header not preceded by preamble.");
	word_length_a: assert property (
		cq.st == hcw_pkg::TX_DATA |-> cq.bit_idx <= hcw_pkg::WORD_LAST_IDX)
		else $error("Bit index beyond word.");
	guard_follows_a: assert property (
		cq.st == hcw_pkg::TX_GUARD && nx.st == hcw_pkg::TX_PREP
		|-> third_tick && cq.thirds == hcw_pkg::GUARD_THIRDS - 8'h1)
		else $error("Frame started without guard.");
	fixed_field_a: assert property (
		cq.st == hcw_pkg::TX_HEADER && !i_config.extended_serial_select |-> cq.word[63:60] == cq.func)
		else $error("Function bits missing from fixed block.");
	checksum_value_a: assert property (
		cq.st == hcw_pkg::TX_DATA && cq.bit_idx == hcw_pkg::CRC0_IDX |-> cq.crc == hcw_pkg::crc_over(cq.word[64:0]))
		else $error("Checksum mismatch.");
	battery_flag_a: assert property (
		cq.st == hcw_pkg::TX_PREAMBLE && $past(cq.st) == hcw_pkg::TX_LOAD |-> cq.word[64] == $past(i_low_supply_indicator))
		else $error("Low battery flag not captured.");
	timeout_quiet_a: assert property (
		cq.st == hcw_pkg::TX_TIMEOUT ##1 cq.st == hcw_pkg::TX_TIMEOUT |-> !o_tx_data && o_indicator_output_n)
		else $error("Output active during time-out.");
	two_words_a: assert property (
		$rose(cq.st == hcw_pkg::TX_IDLE) && $past(cq.st) == hcw_pkg::TX_GUARD |-> cq.words_done == hcw_pkg::WORDS_MIN)
		else $error("Slept before two words.");
	abort_restart_a: assert property (
		framing && i_button != 4'h0 && i_button != cq.func && !prog_busy && !i_config.timeout_enable
		|=> cq.st == hcw_pkg::TX_PREP ##1 cq.func == $past(i_button, 2))
		else $error("Abort did not restart with new buttons.");
endmodule : hcw_transmitter

// *** test/hcw_rf_rx.sv ***
// Radio stage model: recovers 67-bit words from the pulse-width transmit line.
// Assumes cells of three thirds of THIRD clocks each and a header of about 30 low thirds.
`timescale 1ns/100ps
module hcw_rf_rx #(
	parameter int THIRD = 4
) (
	// Clock and line
	input  wire logic   i_clock,
	input  wire logic   i_line,
	// Recovered words
	output logic [66:0] o_word,
	output logic [7:0]  o_words,
	output logic [6:0]  o_bits
);
	logic        line_q = 1'b0;
	logic        in_data = 1'b0;
	int          run = 0;
	logic [66:0] word_q = '0;
	logic [7:0]  words_q = 8'h00;
	logic [6:0]  bits_q = 7'h00;

	assign o_word = word_q;
	assign o_words = words_q;
	assign o_bits = bits_q;

	always @(posedge i_clock) begin
		line_q <= i_line;
		if (i_line != line_q) run <= 1;
		else run <= run + 1;
		if (i_line && !line_q && run >= 25 * THIRD && run <= 45 * THIRD) begin
			in_data <= 1'b1;
			bits_q <= 7'h00;
		end
		// A one is a single high third, a zero two high thirds.
		if (!i_line && line_q && in_data) begin
			word_q[bits_q] <= (run < 3 * THIRD / 2);
			bits_q <= bits_q + 7'h01;
			if (bits_q == 7'h42) begin
				in_data <= 1'b0;
				words_q <= words_q + 8'h01;
			end
		end
	end
endmodule : hcw_rf_rx

// *** test/tb.sv ***
// Testbench of the rolling-code word transmitter with a radio stage receiver model.
// Assumes a shortened millisecond tick of 2 clocks and a third of 4 clocks.
`timescale 1ns/100ps
module tb;
	localparam logic [31:0] KEY = 32'hA5C3_0F96;
	localparam int FRAME = 1536;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [3:0] button = 4'h0;
	logic low_sup = 1'b0;
	hcw_pkg::hcw_config_t cfg = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h2, 32'h9ABC_DEF1};
	logic [31:0] hop_plain;
	logic tx_data, oe_n, led_n, awake;
	logic [66:0] word;
	logic [7:0] words;
	logic [6:0] rx_bits;
	int error_cnt = 0;
	int comparisons = 0;
	int n;
	logic pg_data = 1'b0;
	logic [191:0] nv_data;
	logic nv_valid;
	logic led_prev = 1'b1;
	int led_flips = 0;

	always #2.5 clock = ~clock;

	hcw_transmitter #(.MS_TICK_CYC(2), .THIRD_CELL_CYC(4), .ENTRY_HOLD_CYC(20), .ENTRY_SETUP_CYC(40),
		.WRITE_CYC(20)) i_dut (.i_clock(clock), .i_srst(srst),
		.i_button(button), .i_low_supply_indicator(low_sup), .i_config(cfg),
		.i_hop_cipher(hop_plain ^ KEY), .o_hop_plain(hop_plain), .i_tx_pin(oe_n ? pg_data : tx_data),
		.o_tx_data(tx_data), .o_tx_oe_n(oe_n), .o_indicator_output_n(led_n), .o_awake(awake),
		.o_nv_data(nv_data), .o_nv_valid(nv_valid));
	hcw_rf_rx #(.THIRD(4)) i_rx (.i_clock(clock), .i_line(tx_data), .o_word(word), .o_words(words),
		.o_bits(rx_bits));

	always @(negedge clock) begin
		if (awake && led_n !== led_prev) led_flips++;
		led_prev = led_n;
	end

	task automatic check(input string name, input logic [191:0] exp, input logic [191:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic give_verdict();
		if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic wait_idle(output int k);
		k = 0;
		while (awake !== 1'b0 && k < 8 * FRAME) begin
			@(negedge clock);
			k++;
		end
	endtask : wait_idle

	task automatic wait_word(input logic [7:0] w0);
		for (int k = 0; words == w0 && k < 3 * FRAME; k++) @(negedge clock);
	endtask : wait_word

	// The checksum bits are recomputed over the expected bits 0 to 64.
	task automatic check_word(input logic [3:0] f, input logic x, input logic lo, input logic [15:0] s);
		logic [66:0] e;
		logic [1:0] c;
		e[15:0] = s ^ KEY[15:0];
		e[31:16] = {f, 4'hE, cfg.serial_number[7:0]} ^ KEY[31:16];
		e[63:32] = x ? cfg.serial_number : {f, cfg.serial_number[27:0]};
		e[64] = lo;
		c = 2'h0;
		for (int k = 0; k < 65; k++) c = {c[0] ^ e[k], c[0] ^ e[k] ^ c[1]};
		e[66:65] = {c[1], c[0]};
		check("code word", e, word);
	endtask : check_word

	task automatic run_word(input logic [3:0] f, input logic x, input logic lo, input logic abrt,
		input logic [15:0] s);
		logic [7:0] w0;
		w0 = words;
		led_flips = 0;
		cfg.extended_serial_select = x;
		low_sup = lo;
		button = abrt ? 4'h1 : f;
		repeat (10) @(negedge clock);
		if (abrt) begin
			for (int k = 0; rx_bits != 7'h05 && k < 2 * FRAME; k++) @(negedge clock);
			button = f;
			repeat (10) @(negedge clock);
		end
		button = 4'h0;
		wait_word(w0);
		check_word(f, x, lo, s);
		if (!lo) check("indicator", 67'h0, 67'(led_n));
		wait_idle(n);
		check("indicator flips", 67'h1, 67'(lo ? led_flips >= 3 : led_flips == 1));
		check("word count", 67'(w0 + 8'h2), 67'(words));
		check("indicator off", 67'h1, 67'(led_n));
	endtask : run_word

	// Programming station: entry, twelve word pairs with acknowledges, then the one verify pass.
	task automatic prog_all();
		logic [191:0] img;
		logic [15:0] w;
		// Hold button 3, release, raise data in the setup window
		// Buttons 0 and 1 stay low
		button = 4'h8;
		repeat (30) @(negedge clock);
		button = 4'h0;
		repeat (5) @(negedge clock);
		pg_data = 1'b1;
		repeat (5) @(negedge clock);
		for (int k = 0; k < 12; k++) begin
			w = {12'hC5A, 4'(k)};
			img[k * 16 +: 16] = w;
			for (int b = 0; b < 32; b++) begin
				button = 4'h8;
				pg_data = (b < 16) ? w[b] : ~w[b - 16];
				repeat (3) @(negedge clock);
				button = 4'h0;
				repeat (3) @(negedge clock);
			end
			repeat (30) @(negedge clock);
			check("write acknowledge", 67'h1, 67'(tx_data & ~oe_n));
		end
		for (int b = 0; b < 192; b++) begin
			button = 4'h8;
			repeat (3) @(negedge clock);
			check("verify bit", 67'(img[b]), 67'(tx_data));
			button = 4'h0;
			repeat (3) @(negedge clock);
		end
		repeat (5) @(negedge clock);
		check("stored image", img, nv_data);
		check("image valid", 67'h1, 67'(nv_valid));
	endtask : prog_all

	initial begin
		#(95000 * 5);
		error_cnt++;
		give_verdict();
	end

	initial begin
		repeat (12) @(negedge clock);
		srst = 1'b0;
		check("reset outputs", 67'h1, 67'({awake, tx_data, led_n}));
		run_word(4'h1, 1'b0, 1'b0, 1'b0, 16'h0001);
		run_word(4'h6, 1'b1, 1'b1, 1'b0, 16'h0003);
		run_word(4'h3, 1'b0, 1'b0, 1'b1, 16'h0006);
		cfg.long_guard_enable = 1'b1;
		run_word(4'h2, 1'b0, 1'b0, 1'b0, 16'h0008);
		check("long guard span", 67'h1, 67'(n > 3 * FRAME / 2));
		cfg.long_guard_enable = 1'b0;
		cfg.timeout_enable = 1'b1;
		n = words;
		button = 4'h4;
		repeat (50000 + 2 * FRAME) @(negedge clock);
		check("repeated words", 67'h1, 67'(words - n >= 3));
		n = 0;
		for (int k = 0; k < FRAME; k++) begin
			@(negedge clock);
			n = n | tx_data | !led_n;
		end
		check("time-out quiet", 67'h0, 67'(n));
		button = 4'h0;
		wait_idle(n);
		check("asleep", 67'h0, 67'(awake));
		prog_all();
		give_verdict();
	end
endmodule : tb
